// >>> shared/csb_pkg.sv
// constants, types and helpers shared by the bus command controller design
// assumes one 40 MHz clock and a synchronous active-high reset
`default_nettype none

package csb_pkg;

	// clock and timing
	localparam int CSB_CLK_PERIOD_NS = 25;
	localparam int CSB_GRANT_MIN_NS = 110;
	localparam int CSB_GRANT_MAX_NS = 250;
	// least time rounds up and is never below one cycle, longest rounds down
	localparam int CSB_GRANT_MIN_CYC_RAW = (CSB_GRANT_MIN_NS + CSB_CLK_PERIOD_NS - 1) / CSB_CLK_PERIOD_NS;
	localparam int CSB_GRANT_MIN_CYC = (CSB_GRANT_MIN_CYC_RAW < 1) ? 1 : CSB_GRANT_MIN_CYC_RAW;
	localparam int CSB_GRANT_MAX_CYC = CSB_GRANT_MAX_NS / CSB_CLK_PERIOD_NS;
	localparam int CSB_PROC_DIV = 5;

	// register map
	localparam int CSB_ADDR_W = 8;
	localparam int CSB_DATA_W = 32;
	localparam logic [7:0] CSB_ADDR_CTRL = 8'h00;
	localparam logic [7:0] CSB_ADDR_STATUS = 8'h04;
	localparam logic [7:0] CSB_ADDR_COUNT = 8'h08;
	localparam int CSB_CTRL_SW_EN_BIT = 0;
	localparam int CSB_CTRL_MCE_MASK_BIT = 1;
	localparam logic [1:0] CSB_CTRL_RESET = 2'h3;
	localparam int CSB_STAT_CODE_LSB = 0;
	localparam int CSB_STAT_STATE_LSB = 3;
	localparam int CSB_STAT_STRAP_BIT = 5;
	localparam int CSB_STAT_GRANT_BIT = 6;
	localparam int CSB_STAT_BUSY_BIT = 7;
	localparam int CSB_COUNT_W = 16;

	// processor status codes
	localparam logic [2:0] CSB_ST_IRQ_ACK = 3'h0;
	localparam logic [2:0] CSB_ST_IO_RD = 3'h1;
	localparam logic [2:0] CSB_ST_IO_WR = 3'h2;
	localparam logic [2:0] CSB_ST_HALT = 3'h3;
	localparam logic [2:0] CSB_ST_CODE_RD = 3'h4;
	localparam logic [2:0] CSB_ST_MEM_RD = 3'h5;
	localparam logic [2:0] CSB_ST_MEM_WR = 3'h6;
	localparam logic [2:0] CSB_ST_PASSIVE = 3'h7;

	typedef enum logic [2:0] {
		CSB_CMD_NONE = 3'h0,
		CSB_CMD_IRQ_ACK = 3'h1,
		CSB_CMD_IO_RD = 3'h2,
		CSB_CMD_IO_WR = 3'h3,
		CSB_CMD_MEM_RD = 3'h4,
		CSB_CMD_MEM_WR = 3'h5
	} csb_cmd_t;

	// gray codes along idle, address, early, late
	typedef enum logic [1:0] {
		CSB_IDLE = 2'h0,
		CSB_ADDR = 2'h1,
		CSB_EARLY = 2'h3,
		CSB_LATE = 2'h2
	} csb_state_t;

	function automatic csb_cmd_t csb_decode(input logic [2:0] code);
		csb_cmd_t cmd;
		cmd = CSB_CMD_NONE;
		case (code)
			CSB_ST_IRQ_ACK: cmd = CSB_CMD_IRQ_ACK;
			CSB_ST_IO_RD: cmd = CSB_CMD_IO_RD;
			CSB_ST_IO_WR: cmd = CSB_CMD_IO_WR;
			CSB_ST_CODE_RD, CSB_ST_MEM_RD: cmd = CSB_CMD_MEM_RD;
			CSB_ST_MEM_WR: cmd = CSB_CMD_MEM_WR;
			default: cmd = CSB_CMD_NONE;
		endcase
		return cmd;
	endfunction : csb_decode

	function automatic logic csb_is_io(input csb_cmd_t cmd);
		return (cmd == CSB_CMD_IRQ_ACK) || (cmd == CSB_CMD_IO_RD) || (cmd == CSB_CMD_IO_WR);
	endfunction : csb_is_io

endpackage : csb_pkg

`default_nettype wire

// >>> core/csb_tick_div.sv
// divides the system clock into a one-cycle processor-state enable
// assumes one clock; tick is high for exactly one cycle in every DIV
`default_nettype none

module csb_tick_div
	import csb_pkg::*;
#(
	parameter int DIV = CSB_PROC_DIV
) (
	input wire logic clock,
	input wire logic rst,
	output logic tick
);

	localparam int CW = $clog2(DIV + 1);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] count_reg;

	always_ff @(posedge clock) begin
		if (rst) begin
			count_reg <= '0;
		end else if (count_reg == LAST) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_reg + CW'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			tick <= 1'b0;
		end else begin
			tick <= (count_reg == LAST);
		end
	end

endmodule : csb_tick_div

`default_nettype wire

// >>> core/csb_grant_timer.sv
// measures how long the arbiter grant has been held low
// assumes grant is synchronous; ready drops in the same cycle grant goes high
`default_nettype none

module csb_grant_timer
	import csb_pkg::*;
#(
	parameter int MIN_CYC = CSB_GRANT_MIN_CYC
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic arbiterGrant_n,
	output logic ready
);

	localparam int CW = $clog2(MIN_CYC + 1);
	localparam logic [CW-1:0] DONE = CW'(MIN_CYC);

	logic [CW-1:0] count_reg;

	// saturating count; restarts whenever the grant is withdrawn
	always_ff @(posedge clock) begin
		if (rst || arbiterGrant_n) begin
			count_reg <= '0;
		end else if (count_reg != DONE) begin
			count_reg <= count_reg + CW'(1);
		end
	end

	// combinational release so drivers float at once
	assign ready = !arbiterGrant_n && (count_reg == DONE);

endmodule : csb_grant_timer

`default_nettype wire

// >>> core/csb_cmd_ctrl.sv
// bus command controller: status decode, command strobes, latch and transceiver control
// assumes status, grant, gate and strap are synchronous to clock; registers on a plain strobe port
//
// Contract
// - passive status keeps every command strobe high.
// - strobes and controls come from the three status inputs at machine-cycle points.
// - all command and control timing comes from the clock input.
// - address latch strobe is active high; latching on its falling edge.
// - transceiver enable is active high while data moves.
// - direction high for writes, low for reads.
// - commands enabled 110 to 250 ns after grant goes low.
// - grant going high floats command drivers at once.
// - io-bus mode ignores grant for io command lines.
// - command gate low forces commands and both data enables inactive.
// - strap high selects io-bus mode, low selects system-bus mode.
// - early io write is active low with read timing, before io write.
// - io write strobe is active low.
// - io read strobe is active low.
// - status code table maps to interrupt ack, io, halt, memory, passive.
// - memory read, memory writes and interrupt ack are active low; early write uses read timing.
// - dual output is cascade enable in system mode, peripheral enable low in io mode.
// - system mode makes memory and io commands wait for the grant.
//
// The address map and strobed register access are this design's own decisions.
`default_nettype none

module csb_cmd_ctrl
	import csb_pkg::*;
#(
	parameter int PROC_DIV = CSB_PROC_DIV,
	parameter int GRANT_MIN_CYC = CSB_GRANT_MIN_CYC
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic statusInBit0,
	input wire logic statusInBit1,
	input wire logic statusInBit2,
	input wire logic arbiterGrant_n,
	input wire logic cmdGate,
	input wire logic ioBusStrap,
	output logic addrLatchStrobe,
	output logic xcvrEnable,
	output logic xferDirection,
	output logic cascadeOrPeriphEnable,
	output logic irqAck_n,
	output logic ioRead_n,
	output logic ioWrite_n,
	output logic earlyIoWrite_n,
	output logic memRead_n,
	output logic memWrite_n,
	output logic earlyMemWrite_n,
	output logic ioCmdOe_n,
	output logic memCmdOe_n,
	input wire logic [CSB_ADDR_W-1:0] regAddr,
	input wire logic [CSB_DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [CSB_DATA_W-1:0] regRdata
);

	logic procTick;
	logic grantReady;
	logic [2:0] statusCode;
	csb_cmd_t statusCmd;
	csb_state_t state_reg;
	csb_state_t state_next;
	csb_cmd_t cmd_reg;
	logic [2:0] code_reg;
	logic ioMode_reg;
	logic swEnable_reg;
	logic mceMaskFirst_reg;
	logic intaSecond_reg;
	logic [CSB_COUNT_W-1:0] cmdCount_reg;
	logic cycleActive;
	logic cmdPhase;
	logic latePhase;
	logic ioCycle;
	logic ioFree;
	logic cmdAllowed;
	logic gateOn;

	// processor state rate, one enable pulse per processor clock
	csb_tick_div #(
		.DIV(PROC_DIV)
	) u_div (
		.clock(clock),
		.rst(rst),
		.tick(procTick)
	);

	csb_grant_timer #(
		.MIN_CYC(GRANT_MIN_CYC)
	) u_grant (
		.clock(clock),
		.rst(rst),
		.arbiterGrant_n(arbiterGrant_n),
		.ready(grantReady)
	);

	assign statusCode = {statusInBit2, statusInBit1, statusInBit0};
	assign statusCmd = csb_decode(statusCode);

	// strap only changes the mode register between cycles; the dual output follows the strap directly, even mid-cycle
	always_ff @(posedge clock) begin
		if (rst) begin
			ioMode_reg <= 1'b0;
		end else if (state_reg == CSB_IDLE) begin
			ioMode_reg <= ioBusStrap;
		end
	end

	// machine cycle sequencer, advanced only on processor ticks
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			CSB_IDLE: begin
				if (procTick && statusCmd != CSB_CMD_NONE) begin
					state_next = CSB_ADDR;
				end
			end
			CSB_ADDR: begin
				if (procTick) begin
					state_next = CSB_EARLY;
				end
			end
			CSB_EARLY: begin
				if (procTick) begin
					state_next = (statusCode == CSB_ST_PASSIVE) ? CSB_IDLE : CSB_LATE;
				end
			end
			CSB_LATE: begin
				if (procTick && statusCode == CSB_ST_PASSIVE) begin
					state_next = CSB_IDLE;
				end
			end
			default: state_next = CSB_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= CSB_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// halt and passive start no cycle; the command is frozen for the whole cycle
	always_ff @(posedge clock) begin
		if (rst) begin
			cmd_reg <= CSB_CMD_NONE;
			code_reg <= CSB_ST_PASSIVE;
		end else if (state_reg == CSB_IDLE && state_next == CSB_ADDR) begin
			cmd_reg <= statusCmd;
			code_reg <= statusCode;
		end
	end

	// interrupt acknowledges come in pairs; the first carries no data
	always_ff @(posedge clock) begin
		if (rst) begin
			intaSecond_reg <= 1'b0;
		end else if (state_reg == CSB_IDLE && state_next == CSB_ADDR) begin
			if (statusCmd == CSB_CMD_IRQ_ACK) begin
				intaSecond_reg <= (cmd_reg == CSB_CMD_IRQ_ACK) && !intaSecond_reg;
			end else begin
				intaSecond_reg <= 1'b0;
			end
		end
	end

	assign cycleActive = (state_reg != CSB_IDLE);
	assign cmdPhase = (state_reg == CSB_EARLY) || (state_reg == CSB_LATE);
	assign latePhase = (state_reg == CSB_LATE);
	assign ioCycle = csb_is_io(cmd_reg);
	assign ioFree = ioMode_reg && ioCycle;
	assign gateOn = cmdGate && swEnable_reg;
	// system mode holds every command until the arbiter grant has settled
	assign cmdAllowed = gateOn && (ioFree || grantReady);

	// address latch strobe high for the address state; the falling edge latches
	always_ff @(posedge clock) begin
		if (rst) begin
			addrLatchStrobe <= 1'b0;
		end else begin
			addrLatchStrobe <= (state_next == CSB_ADDR);
		end
	end

	// direction set from the start of the cycle so transceivers turn before data
	always_ff @(posedge clock) begin
		if (rst) begin
			xferDirection <= 1'b0;
		end else if (state_next == CSB_ADDR) begin
			xferDirection <= (statusCmd == CSB_CMD_IO_WR) || (statusCmd == CSB_CMD_MEM_WR);
		end else if (state_next == CSB_IDLE) begin
			xferDirection <= 1'b0;
		end
	end

	// system transceiver; io-bus cycles in io mode use the peripheral enable instead
	always_ff @(posedge clock) begin
		if (rst) begin
			xcvrEnable <= 1'b0;
		end else begin
			xcvrEnable <= (state_next == CSB_EARLY || state_next == CSB_LATE) && gateOn && !ioFree;
		end
	end

	// dual output: cascade enable high in system mode, peripheral enable low in io mode
	always_ff @(posedge clock) begin
		if (rst) begin
			cascadeOrPeriphEnable <= 1'b0;
		end else if (ioBusStrap) begin
			cascadeOrPeriphEnable <= !((state_next == CSB_EARLY || state_next == CSB_LATE) && gateOn && ioFree);
		end else begin
			cascadeOrPeriphEnable <= (state_next == CSB_ADDR || state_next == CSB_EARLY) && gateOn
				&& (state_reg == CSB_IDLE ? statusCmd : cmd_reg) == CSB_CMD_IRQ_ACK
				&& (!mceMaskFirst_reg || (state_reg == CSB_IDLE
				? (cmd_reg == CSB_CMD_IRQ_ACK && !intaSecond_reg) : intaSecond_reg));
		end
	end

	// read-type strobes and the early writes share the early phase
	always_ff @(posedge clock) begin
		if (rst) begin
			irqAck_n <= 1'b1;
			ioRead_n <= 1'b1;
			earlyIoWrite_n <= 1'b1;
			memRead_n <= 1'b1;
			earlyMemWrite_n <= 1'b1;
		end else if (!cmdPhase || !cmdAllowed || state_next == CSB_IDLE) begin
			irqAck_n <= 1'b1;
			ioRead_n <= 1'b1;
			earlyIoWrite_n <= 1'b1;
			memRead_n <= 1'b1;
			earlyMemWrite_n <= 1'b1;
		end else begin
			irqAck_n <= !(cmd_reg == CSB_CMD_IRQ_ACK);
			ioRead_n <= !(cmd_reg == CSB_CMD_IO_RD);
			earlyIoWrite_n <= !(cmd_reg == CSB_CMD_IO_WR);
			memRead_n <= !(cmd_reg == CSB_CMD_MEM_RD);
			earlyMemWrite_n <= !(cmd_reg == CSB_CMD_MEM_WR);
		end
	end

	// ordinary writes wait for the late phase so write data is already on the bus
	always_ff @(posedge clock) begin
		if (rst) begin
			ioWrite_n <= 1'b1;
			memWrite_n <= 1'b1;
		end else if (!latePhase || !cmdAllowed || state_next == CSB_IDLE) begin
			ioWrite_n <= 1'b1;
			memWrite_n <= 1'b1;
		end else begin
			ioWrite_n <= !(cmd_reg == CSB_CMD_IO_WR);
			memWrite_n <= !(cmd_reg == CSB_CMD_MEM_WR);
		end
	end

	// memory driver enable, and the io one in system mode, react in the same cycle the grant is withdrawn
	assign ioCmdOe_n = !(ioMode_reg || grantReady);
	assign memCmdOe_n = !grantReady;

	// machine cycles, counted once per cycle on entry to the early phase, even when gate or grant holds the strobes off
	always_ff @(posedge clock) begin
		if (rst) begin
			cmdCount_reg <= '0;
		end else if (state_reg == CSB_ADDR && procTick) begin
			cmdCount_reg <= cmdCount_reg + CSB_COUNT_W'(1);
		end
	end

	// control register
	always_ff @(posedge clock) begin
		if (rst) begin
			swEnable_reg <= CSB_CTRL_RESET[CSB_CTRL_SW_EN_BIT];
			mceMaskFirst_reg <= CSB_CTRL_RESET[CSB_CTRL_MCE_MASK_BIT];
		end else if (regWr && regAddr == CSB_ADDR_CTRL) begin
			swEnable_reg <= regWdata[CSB_CTRL_SW_EN_BIT];
			mceMaskFirst_reg <= regWdata[CSB_CTRL_MCE_MASK_BIT];
		end
	end

	// read data stand for one cycle only; unmapped reads return zero
	always_ff @(posedge clock) begin
		if (rst) begin
			regRdata <= '0;
		end else if (!regRd) begin
			regRdata <= '0;
		end else if (regAddr == CSB_ADDR_CTRL) begin
			regRdata <= {{(CSB_DATA_W-2){1'b0}}, mceMaskFirst_reg, swEnable_reg};
		end else if (regAddr == CSB_ADDR_STATUS) begin
			regRdata <= {{(CSB_DATA_W-8){1'b0}}, cycleActive, grantReady, ioMode_reg, state_reg, code_reg};
		end else if (regAddr == CSB_ADDR_COUNT) begin
			regRdata <= {{(CSB_DATA_W-CSB_COUNT_W){1'b0}}, cmdCount_reg};
		end else begin
			regRdata <= '0;
		end
	end

endmodule : csb_cmd_ctrl

`default_nettype wire

// >>> sim/csb_cmd_ctrl_properties.sv
// port assertions for the bus command controller
// assumes the bench binds it to the top module; plain numbers fit PROC_DIV up to 5
`default_nettype none
module csb_cmd_ctrl_checker (
	input wire logic clock,
	input wire logic rst,
	input wire logic statusInBit0,
	input wire logic statusInBit1,
	input wire logic statusInBit2,
	input wire logic arbiterGrant_n,
	input wire logic cmdGate,
	input wire logic ioBusStrap,
	input wire logic addrLatchStrobe,
	input wire logic xcvrEnable,
	input wire logic xferDirection,
	input wire logic irqAck_n,
	input wire logic ioRead_n,
	input wire logic ioWrite_n,
	input wire logic earlyIoWrite_n,
	input wire logic memRead_n,
	input wire logic memWrite_n,
	input wire logic earlyMemWrite_n,
	input wire logic ioCmdOe_n,
	input wire logic memCmdOe_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire logic allHigh;
	assign allHigh = irqAck_n & ioRead_n & ioWrite_n & earlyIoWrite_n & memRead_n & memWrite_n & earlyMemWrite_n;
	passive_idle_a: assert property ((statusInBit0 & statusInBit1 & statusInBit2)[*6] |-> allHigh)
		else $error("strobe low while passive");
	gate_forces_off_a: assert property ((!cmdGate)[*2] |-> allHigh && !xcvrEnable)
		else $error("gate low but outputs active");
	latch_before_cmd_a: assert property (addrLatchStrobe |-> allHigh && !xcvrEnable)
		else $error("latch strobe overlaps command");
	xcvr_on_mem_a: assert property (!memRead_n || !earlyMemWrite_n |-> xcvrEnable)
		else $error("transceiver off during memory command");
	dir_write_a: assert property (!memWrite_n || !ioWrite_n |-> xferDirection)
		else $error("direction low on write");
	dir_read_a: assert property (!memRead_n || !ioRead_n || !irqAck_n |-> !xferDirection)
		else $error("direction high on read");
	early_io_first_a: assert property ($fell(ioWrite_n) |-> !$past(earlyIoWrite_n) && !earlyIoWrite_n)
		else $error("early io write not ahead");
	early_mem_first_a: assert property ($fell(memWrite_n) |-> !$past(earlyMemWrite_n) && !earlyMemWrite_n)
		else $error("early memory write not ahead");
	grant_delay_a: assert property ($fell(arbiterGrant_n) |-> memCmdOe_n[*4] ##[1:7] (!memCmdOe_n || arbiterGrant_n))
		else $error("command enable outside grant window");
	release_float_a: assert property (arbiterGrant_n |-> memCmdOe_n && (ioBusStrap || ioCmdOe_n))
		else $error("drivers not floated on release");
	io_mode_free_a: assert property (ioBusStrap[*4] |-> !ioCmdOe_n)
		else $error("io lines floated in io mode");
	sys_io_waits_a: assert property ($fell(ioRead_n) && !ioBusStrap |-> !arbiterGrant_n && !ioCmdOe_n)
		else $error("io command without grant");
endmodule : csb_cmd_ctrl_checker
`default_nettype wire

// >>> sim/csb_cpu_model.sv
// processor status and arbiter model on the far side of the controller
// assumes a go pulse; the code is held eight clocks, then passive
`default_nettype none
module csb_cpu_model (
	input wire logic clock,
	input wire logic go,
	input wire logic [2:0] code,
	input wire logic busFree,
	output logic statusInBit0,
	output logic statusInBit1,
	output logic statusInBit2,
	output logic arbiterGrant_n
);
	logic [3:0] holdCnt = 4'h0;
	logic [2:0] codeReg = 3'h7;
	always_ff @(posedge clock) begin
		if (go) begin
			holdCnt <= 4'h8;
			codeReg <= code;
		end else if (holdCnt != 4'h0) begin
			holdCnt <= holdCnt - 4'h1;
			if (holdCnt == 4'h1) begin
				codeReg <= 3'h7;
			end
		end
	end
	assign {statusInBit2, statusInBit1, statusInBit0} = codeReg;
	// grant only while the bench says the bus is free
	assign arbiterGrant_n = !busFree;
endmodule : csb_cpu_model
`default_nettype wire

// >>> sim/test_cpu_status_bus_command_controller.sv
// bench for the bus command controller with a processor model
// assumes PROC_DIV of 2 so a cycle fits in 24 clocks
`default_nettype none
module test_cpu_status_bus_command_controller;
	timeunit 1ns;
	timeprecision 100ps;
	import csb_pkg::*;
	logic clock, rst, go, busFree, cmdGate, ioBusStrap, regWr, regRd;
	logic [2:0] code;
	logic s0, s1, s2, grant_n, ale, xcvr, dir, cpe, ia_n, ir_n, iw_n, eiw_n, mr_n, mw_n, emw_n;
	logic [7:0] regAddr;
	logic [31:0] regWdata, regRdata, rd;
	logic [10:0] seen;
	int failCount, checksDone, cycles;
	csb_cmd_ctrl #(.PROC_DIV(2)) csb_cmd_ctrl_i (.clock(clock), .rst(rst), .statusInBit0(s0),
		.statusInBit1(s1), .statusInBit2(s2), .arbiterGrant_n(grant_n), .cmdGate(cmdGate),
		.ioBusStrap(ioBusStrap), .addrLatchStrobe(ale), .xcvrEnable(xcvr), .xferDirection(dir),
		.cascadeOrPeriphEnable(cpe), .irqAck_n(ia_n), .ioRead_n(ir_n), .ioWrite_n(iw_n),
		.earlyIoWrite_n(eiw_n), .memRead_n(mr_n), .memWrite_n(mw_n), .earlyMemWrite_n(emw_n),
		.ioCmdOe_n(), .memCmdOe_n(), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata));
	csb_cpu_model csb_cpu_model_i (.clock(clock), .go(go), .code(code), .busFree(busFree),
		.statusInBit0(s0), .statusInBit1(s1), .statusInBit2(s2), .arbiterGrant_n(grant_n));
	always #12.5 clock = ~clock;
	task automatic completeRun;
		$display("checks %0d mismatches %0d", checksDone, failCount);
		if (failCount == 0 && checksDone > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : completeRun
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			failCount++;
			completeRun();
		end
	end
	task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			failCount++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chkReg
	task automatic chkPins(input logic [10:0] got, input logic [10:0] exp);
		checksDone++;
		if (got !== exp) begin
			failCount++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chkPins
	task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clock);
		regWr <= 1'b0;
	endtask : regWrite
	task automatic regRead(input logic [7:0] a);
		@(posedge clock);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clock);
		regRd <= 1'b0;
		#1 rd = regRdata;
	endtask : regRead
	// collects every output but the two command driver enables that went active during one machine cycle
	task automatic runCycle(input logic [2:0] c);
		seen = '0;
		@(posedge clock);
		code <= c;
		go <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
		repeat (24) begin
			@(posedge clock);
			#1 seen = seen | {cpe ^ ioBusStrap, dir, xcvr, ale, ~{ia_n, ir_n, iw_n, eiw_n, mr_n, mw_n, emw_n}};
		end
		// end on an edge so stimulus that follows changes at a rising edge
		@(posedge clock);
	endtask : runCycle
	function automatic logic [10:0] expPins(input logic [2:0] c, input logic io);
		logic [6:0] s;
		logic isIo;
		case (c)
			3'h0: s = 7'h40;
			3'h1: s = 7'h20;
			3'h2: s = 7'h18;
			3'h4, 3'h5: s = 7'h04;
			3'h6: s = 7'h03;
			default: s = 7'h00;
		endcase
		isIo = c < 3'h3;
		return {(c == 3'h0) || (io && isIo), c == 3'h2 || c == 3'h6, s != 7'h0 && !(io && isIo), s != 7'h0, s};
	endfunction : expPins
	initial begin
		clock = 0;
		rst = 1;
		go = 0;
		code = 3'h7;
		busFree = 1;
		cmdGate = 1;
		ioBusStrap = 0;
		regAddr = '0;
		regWdata = '0;
		regWr = 0;
		regRd = 0;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		repeat (10) @(posedge clock);
		regRead(CSB_ADDR_CTRL);
		chkReg(rd, {30'h0, CSB_CTRL_RESET});
		regRead(8'h0c);
		chkReg(rd, 32'h0);
		// cascade mask off so a lone acknowledge shows its cascade enable
		regWrite(CSB_ADDR_CTRL, 32'h1);
		for (int i = 0; i < 8; i++) begin
			runCycle(3'(i));
			chkPins(seen, expPins(3'(i), 1'b0));
		end
		regRead(CSB_ADDR_COUNT);
		chkReg(rd, 32'h6);
		$display("decode test done");
		regWrite(CSB_ADDR_CTRL, 32'h0);
		runCycle(3'h5);
		chkPins(seen & 11'h07f, 11'h000);
		regWrite(CSB_ADDR_CTRL, 32'h1);
		cmdGate <= 1'b0;
		runCycle(3'h5);
		chkPins(seen & 11'h57f, 11'h000);
		cmdGate <= 1'b1;
		$display("gate test done");
		busFree <= 1'b0;
		runCycle(3'h5);
		chkPins(seen & 11'h07f, 11'h000);
		runCycle(3'h1);
		chkPins(seen & 11'h07f, 11'h000);
		ioBusStrap <= 1'b1;
		repeat (4) @(posedge clock);
		runCycle(3'h1);
		chkPins(seen, expPins(3'h1, 1'b1));
		runCycle(3'h0);
		chkPins(seen, expPins(3'h0, 1'b1));
		runCycle(3'h5);
		chkPins(seen & 11'h07f, 11'h000);
		busFree <= 1'b1;
		repeat (12) @(posedge clock);
		runCycle(3'h5);
		chkPins(seen, expPins(3'h5, 1'b1));
		ioBusStrap <= 1'b0;
		repeat (4) @(posedge clock);
		runCycle(3'h2);
		chkPins(seen, expPins(3'h2, 1'b0));
		$display("grant and mode test done");
		// cascade mask on: only the second of two back-to-back acknowledges shows it
		regWrite(CSB_ADDR_CTRL, 32'h3);
		runCycle(CSB_ST_IRQ_ACK);
		chkPins(seen, expPins(CSB_ST_IRQ_ACK, 1'b0) & 11'h3ff);
		runCycle(CSB_ST_IRQ_ACK);
		chkPins(seen, expPins(CSB_ST_IRQ_ACK, 1'b0));
		regRead(CSB_ADDR_STATUS);
		chkReg(rd, (32'h1 << CSB_STAT_GRANT_BIT) | (32'(CSB_ST_IRQ_ACK) << CSB_STAT_CODE_LSB));
		$display("pairing test done");
		completeRun();
	end
endmodule : test_cpu_status_bus_command_controller
bind csb_cmd_ctrl csb_cmd_ctrl_checker csb_cmd_ctrl_checker_i (.clock(clock), .rst(rst),
	.statusInBit0(statusInBit0), .statusInBit1(statusInBit1), .statusInBit2(statusInBit2),
	.arbiterGrant_n(arbiterGrant_n), .cmdGate(cmdGate), .ioBusStrap(ioBusStrap),
	.addrLatchStrobe(addrLatchStrobe), .xcvrEnable(xcvrEnable), .xferDirection(xferDirection),
	.irqAck_n(irqAck_n), .ioRead_n(ioRead_n), .ioWrite_n(ioWrite_n), .earlyIoWrite_n(earlyIoWrite_n),
	.memRead_n(memRead_n), .memWrite_n(memWrite_n), .earlyMemWrite_n(earlyMemWrite_n),
	.ioCmdOe_n(ioCmdOe_n), .memCmdOe_n(memCmdOe_n));
`default_nettype wire
